//--- stm_pkg.sv
// constants and carrier types shared by the standard timer core
package stm_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int CNT_W  = 16;
  localparam int BYTE_W = 8;
  localparam int PRE_W  = 6;

  // ---------------------------------------------------------------
  // count clock select codes
  // ---------------------------------------------------------------
  localparam logic [2:0] CKS_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CKS_SYS      = 3'h1;
  localparam logic [2:0] CKS_HI_DIV16 = 3'h2;
  localparam logic [2:0] CKS_HI_DIV64 = 3'h3;
  localparam logic [2:0] CKS_SUB_A    = 3'h4;
  localparam logic [2:0] CKS_SUB_B    = 3'h5;
  localparam logic [2:0] CKS_EXT_RISE = 3'h6;
  localparam logic [2:0] CKS_EXT_FALL = 3'h7;

  // prescaler terminal masks for the divided internal rates
  localparam logic [PRE_W-1:0] PRE_MASK_DIV4  = 6'h03;
  localparam logic [PRE_W-1:0] PRE_MASK_DIV16 = 6'h0f;
  localparam logic [PRE_W-1:0] PRE_MASK_DIV64 = 6'h3f;

  // ---------------------------------------------------------------
  // operating mode field codes
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_UNDEF   = 2'h1;
  localparam logic [1:0] MODE_PWM_SP  = 2'h2;
  localparam logic [1:0] MODE_TIMER   = 2'h3;

  // pin function codes, compare match output mode
  localparam logic [1:0] IO_NO_CHANGE = 2'h0;
  localparam logic [1:0] IO_LOW       = 2'h1;
  localparam logic [1:0] IO_HIGH      = 2'h2;
  localparam logic [1:0] IO_TOGGLE    = 2'h3;
  // pin function codes, pwm / single pulse mode
  localparam logic [1:0] IO_PWM_INACT = 2'h0;
  localparam logic [1:0] IO_PWM_ACT   = 2'h1;
  localparam logic [1:0] IO_PWM       = 2'h2;
  localparam logic [1:0] IO_PULSE     = 2'h3;

  // ---------------------------------------------------------------
  // byte access selectors and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] SEL_CNT_LO = 3'h0;
  localparam logic [2:0] SEL_CNT_HI = 3'h1;
  localparam logic [2:0] SEL_CMP_LO = 3'h2;
  localparam logic [2:0] SEL_CMP_HI = 3'h3;
  localparam logic [2:0] SEL_PERIOD = 3'h4;

  localparam logic [CNT_W-1:0]  CNT_RST    = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ALL1   = 16'hffff;
  localparam logic [BYTE_W-1:0] BYTE_RST   = 8'h00;
  localparam logic [PRE_W-1:0]  PRE_RST    = 6'h00;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       enable;
    logic       pause;
    logic [2:0] clk_sel;
    logic [1:0] mode;
    logic [1:0] io_sel;
    logic       init_level;
    logic       clear_on_a;
  } stm_ctrl_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [2:0]  sel;
    logic [7:0]  wdata;
  } stm_acc_s;

  typedef enum logic [1:0] {
    SP_IDLE   = 2'b01,
    SP_ACTIVE = 2'b10
  } stm_pulse_e;

endpackage

//--- stm_core.sv
// standard timer core: 16-bit up counter, two comparators, output pin
`timescale 1ns/1ps
module stm_core
  import stm_pkg::*;
(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  // configuration
  input  wire stm_ctrl_s         i_ctrl,
  // byte access port
  input  wire stm_acc_s          i_acc,
  output logic [BYTE_W-1:0]      o_rd_data,
  output logic                   o_rd_valid,
  // external clock sources
  input  wire logic              i_sub_clock,
  input  wire logic              i_external_count_input,
  // pin and interrupts
  output logic                   o_timer_output_pin,
  output logic                   o_irq_compare_a,
  output logic                   o_irq_period
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic cmp_level(input logic [1:0] io, input logic cur);
    case (io)
      IO_LOW:    cmp_level = 1'b0;
      IO_HIGH:   cmp_level = 1'b1;
      IO_TOGGLE: cmp_level = ~cur;
      default:   cmp_level = cur;
    endcase
  endfunction

  function automatic logic pre_hit(input logic [PRE_W-1:0] pre,
                                   input logic [PRE_W-1:0] mask);
    pre_hit = ((pre & mask) == mask);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [CNT_W-1:0]  count_reg;
  logic [CNT_W-1:0]  count_next;
  logic [CNT_W-1:0]  compare_a_value_reg;
  logic [BYTE_W-1:0] period_compare_value_reg;
  logic [BYTE_W-1:0] hold_buf_reg;
  logic [PRE_W-1:0]  pre_reg;
  logic              enable_d_reg;
  logic              sub_s1_reg;
  logic              sub_s2_reg;
  logic              sub_d_reg;
  logic              ext_s1_reg;
  logic              ext_s2_reg;
  logic              ext_d_reg;
  stm_pulse_e        pulse_reg;
  stm_pulse_e        pulse_next;

  logic              enable_rise;
  logic              ext_rise;
  logic              ext_fall;
  logic              src_tick;
  logic              count_tick;
  logic              hit_a;
  logic              hit_p;
  logic              overflow;
  logic              clear_now;
  logic              pwm_mode;
  logic              pulse_mode;
  logic              pulse_trigger;

  // ---------------------------------------------------------------
  // input synchronisers and edge detection
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sub_s1_reg <= 1'b0;
      sub_s2_reg <= 1'b0;
      sub_d_reg  <= 1'b0;
    end
    else
    begin
      sub_s1_reg <= i_sub_clock;
      sub_s2_reg <= sub_s1_reg;
      sub_d_reg  <= sub_s2_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_d_reg  <= 1'b0;
    end
    else
    begin
      ext_s1_reg <= i_external_count_input;
      ext_s2_reg <= ext_s1_reg;
      ext_d_reg  <= ext_s2_reg;
    end
  end

  assign ext_rise = ext_s2_reg & ~ext_d_reg;
  assign ext_fall = ~ext_s2_reg & ext_d_reg;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      enable_d_reg <= 1'b0;
    else
      enable_d_reg <= i_ctrl.enable;
  end

  assign enable_rise = i_ctrl.enable & ~enable_d_reg;

  // ---------------------------------------------------------------
  // count clock selection
  // ---------------------------------------------------------------
  // the high clock is taken to be the system clock; all three divided
  // rates share one free-running prescaler
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      pre_reg <= PRE_RST;
    else
      pre_reg <= pre_reg + 6'h01;
  end

  always_comb
  begin
    case (i_ctrl.clk_sel)
      CKS_SYS_DIV4: src_tick = pre_hit(pre_reg, PRE_MASK_DIV4);
      CKS_SYS:      src_tick = 1'b1;
      CKS_HI_DIV16: src_tick = pre_hit(pre_reg, PRE_MASK_DIV16);
      CKS_HI_DIV64: src_tick = pre_hit(pre_reg, PRE_MASK_DIV64);
      CKS_SUB_A,
      CKS_SUB_B:    src_tick = sub_s2_reg & ~sub_d_reg;
      CKS_EXT_RISE: src_tick = ext_rise;
      default:      src_tick = ext_fall;
    endcase
  end

  // ---------------------------------------------------------------
  // mode decode and single pulse control
  // ---------------------------------------------------------------
  assign pwm_mode   = (i_ctrl.mode == MODE_PWM_SP) && (i_ctrl.io_sel != IO_PULSE);
  assign pulse_mode = (i_ctrl.mode == MODE_PWM_SP) && (i_ctrl.io_sel == IO_PULSE);
  // the input pin launches the pulse whatever clock is selected
  assign pulse_trigger = pulse_mode && i_ctrl.enable && ext_rise;

  always_comb
  begin
    pulse_next = pulse_reg;
    case (pulse_reg)
      SP_IDLE:
      begin
        if (pulse_trigger)
          pulse_next = SP_ACTIVE;
      end
      SP_ACTIVE:
      begin
        if (!pulse_mode || !i_ctrl.enable || hit_a)
          pulse_next = SP_IDLE;
      end
      default:
        pulse_next = SP_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      pulse_reg <= SP_IDLE;
    else
      pulse_reg <= pulse_next;
  end

  // ---------------------------------------------------------------
  // counter and comparators
  // ---------------------------------------------------------------
  // in pulse mode the counter only runs while a pulse is in flight;
  // undefined mode code leaves the counter stopped
  assign count_tick = src_tick && i_ctrl.enable && !i_ctrl.pause
                      && (i_ctrl.mode != MODE_UNDEF)
                      && (!pulse_mode || (pulse_reg == SP_ACTIVE));

  assign count_next = count_reg + 16'h0001;
  assign overflow   = count_tick && (count_reg == CNT_ALL1);
  assign hit_a      = count_tick && (count_next == compare_a_value_reg);
  // period value counts in blocks of 256; zero means the full range
  assign hit_p      = count_tick && (count_next[7:0] == BYTE_RST)
                      && (count_next[15:8] == period_compare_value_reg);

  assign clear_now  = i_ctrl.clear_on_a ? hit_a : hit_p;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      count_reg <= CNT_RST;
    else if (enable_rise)
      count_reg <= CNT_RST;
    else if (clear_now || overflow)
      count_reg <= CNT_RST;
    else if (count_tick)
      count_reg <= count_next;
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_irq_compare_a <= 1'b0;
      o_irq_period    <= 1'b0;
    end
    else
    begin
      o_irq_compare_a <= hit_a;
      o_irq_period    <= hit_p;
    end
  end

  // ---------------------------------------------------------------
  // timer output pin
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_timer_output_pin <= 1'b0;
    else if (enable_rise && (i_ctrl.mode != MODE_TIMER))
      o_timer_output_pin <= i_ctrl.init_level;
    else if (i_ctrl.mode == MODE_COMPARE)
    begin
      if (hit_a)
        o_timer_output_pin <= cmp_level(i_ctrl.io_sel, o_timer_output_pin);
    end
    else if (pulse_mode)
    begin
      if (pulse_next == SP_ACTIVE)
        o_timer_output_pin <= i_ctrl.init_level;
      else
        o_timer_output_pin <= ~i_ctrl.init_level;
    end
    else if (pwm_mode)
    begin
      // duty from the A value, period from the selected clear source
      case (i_ctrl.io_sel)
        IO_PWM_INACT: o_timer_output_pin <= ~i_ctrl.init_level;
        IO_PWM_ACT:   o_timer_output_pin <= i_ctrl.init_level;
        default:
          if (i_ctrl.enable && (count_reg < compare_a_value_reg))
            o_timer_output_pin <= i_ctrl.init_level;
          else
            o_timer_output_pin <= ~i_ctrl.init_level;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // byte access: compare registers and shared holding buffer
  // ---------------------------------------------------------------
  // software must write low then high and read high then low; any
  // other order returns a stale buffer value, which is by design
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      hold_buf_reg <= BYTE_RST;
    else if (i_acc.wr && (i_acc.sel == SEL_CMP_LO))
      hold_buf_reg <= i_acc.wdata;
    else if (i_acc.rd && (i_acc.sel == SEL_CNT_HI))
      hold_buf_reg <= count_reg[7:0];
    else if (i_acc.rd && (i_acc.sel == SEL_CMP_HI))
      hold_buf_reg <= compare_a_value_reg[7:0];
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      compare_a_value_reg <= CNT_RST;
    else if (i_acc.wr && (i_acc.sel == SEL_CMP_HI))
      compare_a_value_reg <= {i_acc.wdata, hold_buf_reg};
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      period_compare_value_reg <= BYTE_RST;
    else if (i_acc.wr && (i_acc.sel == SEL_PERIOD))
      period_compare_value_reg <= i_acc.wdata;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_rd_data  <= BYTE_RST;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_acc.rd;
      if (!i_acc.rd)
        o_rd_data <= BYTE_RST;
      else if ((i_acc.sel == SEL_CNT_LO) || (i_acc.sel == SEL_CMP_LO))
        o_rd_data <= hold_buf_reg;
      else if (i_acc.sel == SEL_CNT_HI)
        o_rd_data <= count_reg[15:8];
      else if (i_acc.sel == SEL_CMP_HI)
        o_rd_data <= compare_a_value_reg[15:8];
      else if (i_acc.sel == SEL_PERIOD)
        o_rd_data <= period_compare_value_reg;
      else
        o_rd_data <= BYTE_RST;
    end
  end

endmodule // stm_core

//--- stm_core_checker.sv
// port checker for the standard timer core
`timescale 1ns/1ps
module stm_core_checker
  import stm_pkg::*;
(
  // clock and reset
  input wire logic              i_clk,
  input wire logic              i_reset_n,
  // inputs
  input wire stm_ctrl_s         i_ctrl,
  input wire stm_acc_s          i_acc,
  input wire logic              i_sub_clock,
  input wire logic              i_external_count_input,
  // outputs
  input wire logic [BYTE_W-1:0] o_rd_data,
  input wire logic              o_rd_valid,
  input wire logic              o_timer_output_pin,
  input wire logic              o_irq_compare_a,
  input wire logic              o_irq_period
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  logic quiet;
  assign quiet = !o_irq_compare_a && !o_irq_period;

  property p_rd_valid; i_acc.rd |=> o_rd_valid; endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("read strobe without valid pulse");
  property p_rd_only; !i_acc.rd |=> !o_rd_valid; endproperty
  a_rd_only: assert property (p_rd_only)
    else $error("valid pulse without read strobe");
  property p_rd_idle; !o_rd_valid |-> o_rd_data == BYTE_RST; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside valid");
  property p_rd_refused; i_acc.rd && i_acc.sel > SEL_PERIOD |=> o_rd_data == BYTE_RST; endproperty
  a_rd_refused: assert property (p_rd_refused)
    else $error("unmapped read returned data");
  property p_off_quiet; !i_ctrl.enable [*2] |=> quiet; endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("interrupt while disabled");
  property p_pause_quiet; i_ctrl.pause [*2] |=> quiet; endproperty
  a_pause_quiet: assert property (p_pause_quiet)
    else $error("interrupt while paused");
  property p_undef_quiet; (i_ctrl.mode == MODE_UNDEF) [*2] |=> quiet; endproperty
  a_undef_quiet: assert property (p_undef_quiet)
    else $error("interrupt in undefined mode");
  property p_pin_init;
    $rose(i_ctrl.enable) && i_ctrl.mode == MODE_COMPARE
      |=> o_timer_output_pin == $past(i_ctrl.init_level);
  endproperty
  a_pin_init: assert property (p_pin_init)
    else $error("pin not at initial level after enable");
  property p_pin_hold;
    i_ctrl.enable && $past(i_ctrl.enable) && $past(i_ctrl.enable, 2)
      && i_ctrl.mode == MODE_COMPARE && i_ctrl.io_sel == IO_NO_CHANGE
      |-> $stable(o_timer_output_pin);
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("pin moved with no-change setting");
  property p_timer_pin;
    i_ctrl.mode == MODE_TIMER && $past(i_ctrl.mode) == MODE_TIMER
      |-> $stable(o_timer_output_pin);
  endproperty
  a_timer_pin: assert property (p_timer_pin)
    else $error("pin moved in timer mode");
endmodule // stm_core_checker

bind stm_core stm_core_checker u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ctrl(i_ctrl),
  .i_acc(i_acc), .i_sub_clock(i_sub_clock), .i_external_count_input(i_external_count_input),
  .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_timer_output_pin(o_timer_output_pin),
  .o_irq_compare_a(o_irq_compare_a), .o_irq_period(o_irq_period));

//--- stm_ext_model.sv
// far-side model: subsystem clock source and external count pin
`timescale 1ns/1ps
module stm_ext_model (
  // clock
  input  wire logic i_clk,
  // bench control
  input  wire logic i_run,
  // sources seen by the timer
  output logic      o_sub_clock,
  output logic      o_ext_pin
);
  // one driver per output: levels start from declaration values
  int   sub_cnt = 0;
  int   ext_cnt = 0;
  logic sub_lvl = 1'b0;
  logic ext_lvl = 1'b0;
  assign o_sub_clock = sub_lvl;
  assign o_ext_pin   = ext_lvl;
  // sub clock runs free, ten system clocks a period
  always @(posedge i_clk)
  begin
    sub_cnt <= (sub_cnt == 4) ? 0 : sub_cnt + 1;
    if (sub_cnt == 4) sub_lvl <= ~sub_lvl;
  end
  // pin only moves while commanded; a real pin holds its level otherwise
  always @(posedge i_clk)
  begin
    if (i_run)
    begin
      ext_cnt <= (ext_cnt == 2) ? 0 : ext_cnt + 1;
      if (ext_cnt == 2) ext_lvl <= ~ext_lvl;
    end
  end
endmodule // stm_ext_model

//--- stm_core_tb.sv
// self-checking bench for the standard timer core
`timescale 1ns/1ps
module stm_core_tb
  import stm_pkg::*;
;
  typedef struct {
    logic [2:0] cks;
    int         cycles;
  } stm_row_s;
  // three ticks per compare a match at each source's tick spacing
  stm_row_s    rows [8] = '{'{CKS_SYS_DIV4, 12}, '{CKS_SYS, 3}, '{CKS_HI_DIV16, 48},
    '{CKS_HI_DIV64, 192}, '{CKS_SUB_A, 30}, '{CKS_SUB_B, 30}, '{CKS_EXT_RISE, 18},
    '{CKS_EXT_FALL, 18}};
  logic        clk;
  logic        reset_n;
  stm_ctrl_s   ctrl;
  stm_acc_s    acc;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic        sub_clk;
  logic        ext_pin;
  logic        run_ext;
  logic        pin;
  logic        irq_a;
  logic        irq_p;
  logic [7:0]  rd_byte;
  logic [15:0] v1;
  logic [15:0] v2;
  int          n;
  int          hi;
  int          num_errors;
  int          samples_checked;

  stm_core uut (.i_clk(clk), .i_reset_n(reset_n), .i_ctrl(ctrl), .i_acc(acc),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_sub_clock(sub_clk),
    .i_external_count_input(ext_pin), .o_timer_output_pin(pin), .o_irq_compare_a(irq_a),
    .o_irq_period(irq_p));
  stm_ext_model u_far (.i_clk(clk), .i_run(run_ext), .o_sub_clock(sub_clk), .o_ext_pin(ext_pin));
  always #2.5 clk = ~clk;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [2:0] s, input logic [7:0] d);
    @(negedge clk);
    acc = '{wr: w, rd: r, sel: s, wdata: d};
    @(negedge clk);
    acc = '0;
    rd_byte = rd_data;
  endtask
  task automatic set_a(input logic [15:0] v);
    bus(1'b1, 1'b0, SEL_CMP_LO, v[7:0]);
    bus(1'b1, 1'b0, SEL_CMP_HI, v[15:8]);
  endtask
  task automatic rd_cnt(output logic [15:0] v);
    bus(1'b0, 1'b1, SEL_CNT_HI, 8'h00);
    v[15:8] = rd_byte;
    bus(1'b0, 1'b1, SEL_CNT_LO, 8'h00);
    v[7:0] = rd_byte;
  endtask
  // mode and pin settings only change while the counter is off
  task automatic start(input logic [1:0] m, input logic [1:0] io, input logic lv,
                       input logic cl, input logic [2:0] ck);
    @(negedge clk);
    ctrl.enable = 1'b0;
    @(negedge clk);
    ctrl = '{1'b0, 1'b0, ck, m, io, lv, cl};
    @(negedge clk);
    ctrl.enable = 1'b1;
  endtask
  task automatic wait_irq(input logic p, input int lim);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while ((p ? irq_p : irq_a) !== 1'b1 && n < lim);
    if ((p ? irq_p : irq_a) !== 1'b1)
    begin
      num_errors++;
      $display("ERROR %0t no interrupt in time", $time);
      close_out();
    end
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    ctrl = '0;
    acc = '0;
    run_ext = 1'b0;
    num_errors = 0;
    samples_checked = 0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    set_a(16'h0003);
    run_ext = 1'b1;
    foreach (rows[i])
    begin
      start(MODE_TIMER, IO_NO_CHANGE, 1'b0, 1'b1, rows[i].cks);
      wait_irq(1'b0, 400);
      wait_irq(1'b0, 400);
      chk(n, rows[i].cycles, "compare a interval");
    end
    run_ext = 1'b0;
    // second reset in mid-run
    reset_n = 1'b0;
    ctrl = '0;
    repeat (2) @(negedge clk);
    chk({pin, irq_a, irq_p, rd_valid}, 0, "outputs in reset");
    reset_n = 1'b1;
    bus(1'b0, 1'b1, SEL_CMP_HI, 8'h00);
    chk(rd_byte, 8'h00, "compare a after reset");
    // paired byte access
    set_a(16'h1234);
    bus(1'b1, 1'b0, SEL_CMP_LO, 8'h56);
    bus(1'b0, 1'b1, SEL_CMP_HI, 8'h00);
    chk(rd_byte, 8'h12, "compare a high");
    bus(1'b0, 1'b1, SEL_CMP_LO, 8'h00);
    chk(rd_byte, 8'h34, "compare a low");
    bus(1'b0, 1'b1, 3'h5, 8'h00);
    chk(rd_byte, 8'h00, "unmapped read");
    // pause, refused loads, enable edges
    start(MODE_TIMER, IO_NO_CHANGE, 1'b0, 1'b1, CKS_SYS);
    repeat (100) @(negedge clk);
    ctrl.pause = 1'b1;
    rd_cnt(v1);
    bus(1'b1, 1'b0, SEL_CNT_HI, 8'hff);
    bus(1'b1, 1'b0, SEL_CNT_LO, 8'hff);
    repeat (20) @(negedge clk);
    rd_cnt(v2);
    chk(v2, v1, "count moved while paused");
    chk(v1 > 16'd90 && v1 < 16'd110, 1, "count rate");
    ctrl.pause = 1'b0;
    repeat (20) @(negedge clk);
    rd_cnt(v2);
    chk(v2 > v1 + 16'd15, 1, "count after resume");
    ctrl.enable = 1'b0;
    rd_cnt(v1);
    repeat (10) @(negedge clk);
    rd_cnt(v2);
    chk(v2, v1, "count lost when off");
    ctrl.enable = 1'b1;
    rd_cnt(v2);
    chk(v2 < 16'd8, 1, "count not cleared on enable");
    // period comparator on the upper byte
    bus(1'b1, 1'b0, SEL_PERIOD, 8'h01);
    bus(1'b0, 1'b1, SEL_PERIOD, 8'h00);
    chk(rd_byte, 8'h01, "period read back");
    start(MODE_TIMER, IO_NO_CHANGE, 1'b0, 1'b0, CKS_SYS);
    wait_irq(1'b1, 600);
    wait_irq(1'b1, 600);
    chk(n, 256, "period interval");
    // pwm on the timer pin
    set_a(16'h0004);
    start(MODE_PWM_SP, IO_PWM, 1'b1, 1'b0, CKS_SYS);
    wait_irq(1'b1, 600);
    hi = 0;
    repeat (256)
    begin
      @(negedge clk);
      hi += pin;
    end
    chk(hi, 4, "pwm high cycles");
    // forced inactive and active levels, active level high
    for (int k = 0; k < 2; k++)
    begin
      start(MODE_PWM_SP, 2'(k), 1'b1, 1'b0, CKS_SYS);
      repeat (3) @(negedge clk);
      chk(pin, k, "pwm forced level");
    end
    // every compare pin action
    for (int k = 0; k < 4; k++)
    begin
      start(MODE_COMPARE, 2'(k), k == 1, 1'b1, CKS_SYS);
      wait_irq(1'b0, 20);
      chk(pin, k > 1, "pin after match");
    end
    wait_irq(1'b0, 20);
    chk(pin, 0, "second toggle");
    // single pulse launched by the external pin
    start(MODE_PWM_SP, IO_PULSE, 1'b1, 1'b1, CKS_SYS);
    // stop the pin at its first rising edge so exactly one pulse launches
    run_ext = 1'b1;
    hi = 1;
    n = 0;
    while (!(ext_pin === 1'b1 && hi == 0) && n < 20)
    begin
      hi = (ext_pin === 1'b1);
      @(negedge clk);
      n++;
    end
    run_ext = 1'b0;
    if (n >= 20)
    begin
      num_errors++;
      $display("ERROR %0t no trigger edge in time", $time);
      close_out();
    end
    hi = 0;
    repeat (30)
    begin
      @(negedge clk);
      hi += pin;
    end
    chk(hi, 4, "pulse length");
    chk(pin, 0, "pulse end level");
    // undefined mode holds the counter
    start(MODE_UNDEF, IO_NO_CHANGE, 1'b0, 1'b1, CKS_SYS);
    repeat (20) @(negedge clk);
    rd_cnt(v1);
    chk(v1, 16'h0000, "count in undefined mode");
    // wrap from all ones
    set_a(16'h0000);
    bus(1'b1, 1'b0, SEL_PERIOD, 8'h00);
    start(MODE_TIMER, IO_NO_CHANGE, 1'b0, 1'b0, CKS_SYS);
    wait_irq(1'b0, 70000);
    chk(n > 65530 && n < 65545, 1, "wrap interval");
    close_out();
  end
endmodule // stm_core_tb
